// [pkg/conv_defines.svh]
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH

// input undervoltage thresholds, mV
`define CONV_VIN_OFF_MV 16'h2328
`define CONV_VIN_ON_MV 16'h2710
// over-temperature limit, degrees C
`define CONV_OT_LIMIT_C 8'h7D
// power-up limit and retry delay, ms
`define CONV_TON_MAX_MS 8'h14
`define CONV_RETRY_MS 8'h14
// 1 ms tick from a 100 ns clock
`define CONV_CLK_PERIOD_NS 100
`define CONV_TICK_NS 1000000
`define CONV_TICK_CYCLES (`CONV_TICK_NS / `CONV_CLK_PERIOD_NS)
`define CONV_CLK_KHZ 10000
// vout command lsb is 1/512 V (1.953 mV)
`define CONV_VOUT_LSB_SHIFT 9
`define CONV_VOUT_CMD_DFLT 16'h0200
`define CONV_FREQ_STEP_KHZ 16'h0032
// strap codes that mean "pin shorted" / "pin open"
`define CONV_STRAP_SHORT 4'h0
`define CONV_STRAP_OPEN 4'hF
// limit percentages of the target voltage
`define CONV_PCT_PG_ON 7'h5A
`define CONV_PCT_PG_OFF 7'h55
`define CONV_PCT_OV_FAULT 7'h73
`define CONV_PCT_OV_WARN 7'h6E
`define CONV_PCT_UV_WARN 7'h5A
`define CONV_PCT_UV_FAULT 7'h50
`define CONV_PCT_MRG_LO 7'h5F
`define CONV_PCT_MRG_HI 7'h69
// index of the uv fault limit in the limit array
`define CONV_LIM_UV_FAULT 5

`endif

// [pkg/conv_pkg.sv]
package conv_pkg;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_START = 3'b011,
		ST_RUN = 3'b100,
		ST_RETRY = 3'b101
	} state_e;

	typedef enum logic [3:0] {
		CMD_NONE = 4'b0000,
		CMD_VIN_OFF = 4'b0001,
		CMD_VIN_ON = 4'b0010,
		CMD_TON_MAX = 4'b0011,
		CMD_RETRY = 4'b0100,
		CMD_OT_LIMIT = 4'b0101,
		CMD_UV_LIMIT = 4'b0110,
		CMD_VOUT = 4'b0111,
		CMD_FREQ = 4'b1000,
		CMD_INTERLEAVE = 4'b1001,
		CMD_CLEAR = 4'b1010
	} cmd_e;

	typedef enum logic [1:0] {
		MODE_ALONE = 2'b00,
		MODE_MASTER = 2'b01,
		MODE_SLAVE_0 = 2'b10,
		MODE_SLAVE_180 = 2'b11
	} mode_e;

endpackage : conv_pkg

// [pkg/strap_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
	logic [3:0] vcode;
	logic [3:0] rcode;
	logic [15:0] vout_mv;
	logic [15:0] freq_khz;
	logic [1:0] scale;
	logic pmbus_vout;
	modport ctrl (output vcode, rcode,
		input vout_mv, freq_khz, scale, pmbus_vout);
	modport dec (input vcode, rcode,
		output vout_mv, freq_khz, scale, pmbus_vout);
endinterface : strap_if
`default_nettype wire

// [hdl/strap_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "conv_defines.svh"
module strap_decoder (
	strap_if.dec s // strap codes in, table values out
);
	import conv_pkg::*;

	always_comb begin
		s.pmbus_vout = (s.vcode == `CONV_STRAP_SHORT) ||
			(s.vcode == `CONV_STRAP_OPEN);
		case (s.vcode)
			4'h1: s.vout_mv = 16'h0258;
			4'h2: s.vout_mv = 16'h0384;
			4'h3: s.vout_mv = 16'h03B6;
			4'h4: s.vout_mv = 16'h03E8;
			4'h5: s.vout_mv = 16'h041A;
			4'h6: s.vout_mv = 16'h04B0;
			4'h7: s.vout_mv = 16'h04E2;
			4'h8: s.vout_mv = 16'h05DC;
			4'h9: s.vout_mv = 16'h0708;
			4'hA: s.vout_mv = 16'h0834;
			4'hB: s.vout_mv = 16'h09C4;
			4'hC: s.vout_mv = 16'h0CE4;
			4'hD: s.vout_mv = 16'h1388;
			4'hE: s.vout_mv = 16'h2EE0;
			default: s.vout_mv = 16'h0000;
		endcase
		// loop scaling grows with the output range
		if (s.vout_mv > 16'h1388) begin
			s.scale = 2'h3;
		end else if (s.vout_mv > 16'h0CE4) begin
			s.scale = 2'h2;
		end else if (s.vout_mv > 16'h05DC) begin
			s.scale = 2'h1;
		end else begin
			s.scale = 2'h0;
		end
		case (s.rcode)
			4'h2: s.freq_khz = 16'h0190;
			4'h3: s.freq_khz = 16'h01F4;
			4'h4: s.freq_khz = 16'h0226;
			4'h5: s.freq_khz = 16'h0258;
			4'h6: s.freq_khz = 16'h028A;
			4'h7: s.freq_khz = 16'h02BC;
			4'h8: s.freq_khz = 16'h02EE;
			4'h9: s.freq_khz = 16'h0320;
			4'hA: s.freq_khz = 16'h0352;
			4'hB: s.freq_khz = 16'h0384;
			4'hC: s.freq_khz = 16'h03B6;
			4'hD: s.freq_khz = 16'h03E8;
			4'hE: s.freq_khz = 16'h04E2;
			4'hF: s.freq_khz = 16'h05DC;
			// code 1 and a shorted strap (code 0) fall to the lowest rate
			default: s.freq_khz = 16'h012C;
		endcase
	end

endmodule : strap_decoder
`default_nettype wire

// [hdl/sync_clock_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`include "conv_defines.svh"
module sync_clock_gen (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic [15:0] freq_khz, // switching frequency
	input var conv_pkg::mode_e mode, // switching mode
	input wire logic sync_i, // pin level in
	output logic sync_o, // pin level out
	output logic sync_oe, // pin drive enable
	output logic phase_pulse // start of switching period
);
	import conv_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [15:0] cnt;
		logic clk_o;
		logic pulse;
	} sync_s;

	sync_s q;
	sync_s n;
	logic [15:0] half;

	always_comb begin
		n = q;
		half = (freq_khz == 16'h0000) ? 16'h0001 :
			16'((`CONV_CLK_KHZ / 2) / freq_khz);
		n.s1 = sync_i;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.pulse = 1'b0;
		if (q.cnt >= half - 16'h0001) begin
			n.cnt = 16'h0000;
			n.clk_o = ~q.clk_o;
		end else begin
			n.cnt = q.cnt + 16'h0001;
		end
		case (mode)
			MODE_SLAVE_0: n.pulse = q.s2 & ~q.s3;
			MODE_SLAVE_180: n.pulse = ~q.s2 & q.s3;
			default: n.pulse = n.clk_o & ~q.clk_o;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign sync_o = q.clk_o;
	assign sync_oe = (mode == MODE_MASTER);
	assign phase_pulse = q.pulse;

endmodule : sync_clock_gen
`default_nettype wire

// [hdl/converter_fault_and_strap_config.sv]
// Contract
// - input below off threshold flags undervoltage fault, both switches off.
// - undervoltage clears and restart happens only above the on threshold.
// - both input thresholds writable; defaults 9 V off and 10 V on.
// - input, power-up time and temperature faults armed right after lockout.
// - output under uv limit after power-up time gives fault, switches off.
// - after power-up time fault wait retry delay, then start again.
// - power-up time limit and retry delay writable, both default 20 ms.
// - over-temperature turns both switches off; restart once it clears.
// - over-temperature limit writable, default 125 C.
// - pre-biased output above set-point holds both switches off at start.
// - voltage strap selects output, eight limits and loop scaling.
// - fourteen voltage strap codes map 0.60 V up to 12.00 V.
// - limits are fixed percentages of target: 90 85 115 110 90 80 95 105.
// - shorted or open voltage strap means command-set output, 1.953 mV lsb.
// - frequency strap picks one of fifteen rates, 300 to 1500 kHz.
// - frequency command overrides strap, quantised to 50 kHz steps.
// - sync pin drives a clock as master, takes one as slave.
// - four switching modes, master by default, interleave command overrides.
// - output uv limit defaults to 80 % of target and is writable.
`timescale 1ns/1ps
`default_nettype none
`include "conv_defines.svh"
module converter_fault_and_strap_config #(
	parameter int TICK_CYCLES = `CONV_TICK_CYCLES // 1 ms tick divider
) (
	input wire logic clock, // 10 MHz system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic supply_lockout_ok, // internal supply past lockout
	input wire logic [15:0] vin_mv, // measured input voltage
	input wire logic [15:0] vout_mv, // sensed output voltage
	input wire logic [7:0] temp_c, // die temperature
	input wire logic [3:0] vset_strap_code, // voltage strap reading
	input wire logic [3:0] rt_strap_code, // frequency strap reading
	input wire logic cmd_valid, // command strobe
	input var conv_pkg::cmd_e cmd_code, // command select
	input wire logic [15:0] cmd_data, // command value
	input wire logic sync_i, // sync pin level in
	output logic sync_o, // sync pin level out
	output logic sync_oe, // sync pin drive enable
	output logic phase_pulse, // switching period start
	output logic high_side_switch, // high-side enable
	output logic low_side_switch, // low-side enable
	output logic input_undervoltage_protect, // live input uv fault
	output logic powerup_time_protect, // live power-up time fault
	output logic overtemp_fault, // live over-temperature fault
	output logic [2:0] fault_sticky, // {ot, time, input uv}
	output logic [15:0] target_vout_mv, // selected output target
	output logic [7:0][15:0] vout_limits, // derived limits, mV
	output logic [1:0] loop_scale, // loop scaling value
	output logic [15:0] freq_khz, // switching frequency
	output var conv_pkg::mode_e switch_mode, // interleave mode
	output logic [2:0] state_code // control state
);
	import conv_pkg::*;

	typedef struct packed {
		state_e st;
		logic lock_s1;
		logic lock_s2;
		logic [15:0] vin_off;
		logic [15:0] vin_on;
		logic [7:0] ot_lim;
		logic [7:0] ton_max;
		logic [7:0] retry;
		logic [15:0] uv_lim;
		logic uv_ovr;
		logic [15:0] vout_cmd;
		logic vout_ovr;
		logic [15:0] freq;
		logic freq_ovr;
		mode_e mode;
		logic [3:0] vcode;
		logic [3:0] rcode;
		logic [15:0] tick_cnt;
		logic [7:0] ms_cnt;
		logic in_uv;
		logic ot;
		logic ton_f;
		logic [2:0] sticky;
		logic prebias;
		logic sw_on;
		logic [15:0] tgt;
		logic [7:0][15:0] lim;
		logic [15:0] fsel;
		logic [1:0] scale;
	} ctrl_s;

	ctrl_s q;
	ctrl_s n;
	logic tick;
	logic armed;
	logic [15:0] uv_now;
	logic [15:0] cmd_mv;
	logic [15:0] vsel;
	logic [2:0] ev;
	logic [6:0] pcts [8];

	strap_if sif ();

	function automatic logic [15:0] pct(input logic [15:0] v,
		input logic [6:0] p);
		logic [22:0] prod;
		prod = 23'(v) * 23'(p);
		return 16'(prod / 23'd100);
	endfunction : pct

	strap_decoder u_dec (
		.s(sif.dec)
	);

	sync_clock_gen u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.freq_khz(q.fsel),
		.mode(q.mode),
		.sync_i(sync_i),
		.sync_o(sync_o),
		.sync_oe(sync_oe),
		.phase_pulse(phase_pulse)
	);

	assign sif.vcode = q.vcode;
	assign sif.rcode = q.rcode;

	assign pcts[0] = `CONV_PCT_PG_ON;
	assign pcts[1] = `CONV_PCT_PG_OFF;
	assign pcts[2] = `CONV_PCT_OV_FAULT;
	assign pcts[3] = `CONV_PCT_OV_WARN;
	assign pcts[4] = `CONV_PCT_UV_WARN;
	assign pcts[5] = `CONV_PCT_UV_FAULT;
	assign pcts[6] = `CONV_PCT_MRG_LO;
	assign pcts[7] = `CONV_PCT_MRG_HI;

	always_comb begin
		n = q;
		n.lock_s1 = supply_lockout_ok;
		n.lock_s2 = q.lock_s1;
		// protection does not wait for soft-start
		armed = q.lock_s2 && (q.st != ST_OFF);
		tick = 1'b0;
		if (q.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
			n.tick_cnt = 16'h0000;
			tick = 1'b1;
		end else begin
			n.tick_cnt = q.tick_cnt + 16'h0001;
		end
		if (cmd_valid) begin
			case (cmd_code)
				CMD_VIN_OFF: n.vin_off = cmd_data;
				CMD_VIN_ON: n.vin_on = cmd_data;
				CMD_TON_MAX: n.ton_max = cmd_data[7:0];
				CMD_RETRY: n.retry = cmd_data[7:0];
				CMD_OT_LIMIT: n.ot_lim = cmd_data[7:0];
				CMD_UV_LIMIT: begin
					n.uv_lim = cmd_data;
					n.uv_ovr = 1'b1;
				end
				CMD_VOUT: begin
					n.vout_cmd = cmd_data;
					n.vout_ovr = 1'b1;
				end
				CMD_FREQ: begin
					// round down to the nearest whole step
					n.freq = 16'((cmd_data / `CONV_FREQ_STEP_KHZ) *
						`CONV_FREQ_STEP_KHZ);
					n.freq_ovr = 1'b1;
				end
				CMD_INTERLEAVE: n.mode = mode_e'(cmd_data[1:0]);
				default: ;
			endcase
		end
		// vout command in 1/512 V steps converted to mV
		cmd_mv = 16'((32'(q.vout_cmd) * 32'd1000) >>
			`CONV_VOUT_LSB_SHIFT);
		vsel = (sif.pmbus_vout || q.vout_ovr) ? cmd_mv :
			sif.vout_mv;
		n.tgt = vsel;
		for (int i = 0; i < 8; i++) begin
			n.lim[i] = pct(vsel, pcts[i]);
		end
		uv_now = q.uv_ovr ? q.uv_lim :
			q.lim[`CONV_LIM_UV_FAULT];
		if (q.uv_ovr) begin
			n.lim[`CONV_LIM_UV_FAULT] = q.uv_lim;
		end
		n.fsel = q.freq_ovr ? q.freq : sif.freq_khz;
		n.scale = sif.scale;
		// hysteresis: set below off, clear only above on
		if (!armed) begin
			n.in_uv = 1'b0;
		end else if (vin_mv < q.vin_off) begin
			n.in_uv = 1'b1;
		end else if (vin_mv > q.vin_on) begin
			n.in_uv = 1'b0;
		end
		n.ot = armed && (temp_c > q.ot_lim);
		n.ton_f = 1'b0;
		case (q.st)
			ST_OFF: begin
				if (q.lock_s2) begin
					n.st = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				// captured once per lockout release; codes hold until the next pass through ST_OFF
				n.vcode = vset_strap_code;
				n.rcode = rt_strap_code;
				n.st = ST_WAIT;
			end
			ST_WAIT: begin
				// judge pre-bias on entry so the pair never fires for a cycle
				n.prebias = vout_mv > vsel;
				if (!n.in_uv && !n.ot) begin
					n.st = ST_START;
					n.ms_cnt = 8'h00;
				end
			end
			ST_START: begin
				n.prebias = vout_mv > q.tgt;
				if (!n.prebias && vout_mv >= uv_now) begin
					n.st = ST_RUN;
				end else if (q.ms_cnt >= q.ton_max) begin
					n.ton_f = 1'b1;
					n.st = ST_RETRY;
					n.ms_cnt = 8'h00;
				end else if (tick && !n.prebias) begin
					// timer paused while pre-bias holds the stage
					n.ms_cnt = q.ms_cnt + 8'h01;
				end
			end
			ST_RUN: n.prebias = 1'b0;
			ST_RETRY: begin
				n.ton_f = 1'b1;
				if (q.ms_cnt >= q.retry) begin
					n.st = ST_WAIT;
				end else if (tick) begin
					n.ms_cnt = q.ms_cnt + 8'h01;
				end
			end
			default: n.st = ST_OFF;
		endcase
		if ((n.in_uv || n.ot) &&
			(q.st == ST_START || q.st == ST_RUN)) begin
			n.st = ST_WAIT;
		end
		if (!q.lock_s2) begin
			n.st = ST_OFF;
		end
		if (n.st != ST_START) begin
			n.prebias = 1'b0;
		end
		n.sw_on = (n.st == ST_RUN) ||
			(n.st == ST_START && !n.prebias);
		ev = {n.ot, n.ton_f, n.in_uv};
		if (cmd_valid && cmd_code == CMD_CLEAR) begin
			n.sticky = ev;
		end else begin
			n.sticky = q.sticky | ev;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			q <= '0;
			q.st <= ST_OFF;
			q.vin_off <= `CONV_VIN_OFF_MV;
			q.vin_on <= `CONV_VIN_ON_MV;
			q.ot_lim <= `CONV_OT_LIMIT_C;
			q.ton_max <= `CONV_TON_MAX_MS;
			q.retry <= `CONV_RETRY_MS;
			q.vout_cmd <= `CONV_VOUT_CMD_DFLT;
			q.mode <= MODE_MASTER;
		end else begin
			q <= n;
		end
	end

	// both switches share one enable: any fault drops the pair
	assign high_side_switch = q.sw_on;
	assign low_side_switch = q.sw_on;
	assign input_undervoltage_protect = q.in_uv;
	assign powerup_time_protect = q.ton_f;
	assign overtemp_fault = q.ot;
	assign fault_sticky = q.sticky;
	assign target_vout_mv = q.tgt;
	assign vout_limits = q.lim;
	assign loop_scale = q.scale;
	assign freq_khz = q.fsel;
	assign switch_mode = q.mode;
	assign state_code = q.st;

endmodule : converter_fault_and_strap_config
`default_nettype wire

// [verification/board_host.sv]
`timescale 1ns/1ps
`default_nettype none
module board_host (
	input wire logic clock, // system clock
	input wire logic sync_o, // device sync out
	input wire logic sync_oe, // device drives the pin
	output logic sync_i, // resolved pin level
	output logic [3:0] vset_strap_code, // voltage strap
	output logic [3:0] rt_strap_code, // frequency strap
	output logic cmd_valid, // command strobe
	output var conv_pkg::cmd_e cmd_code, // command select
	output logic [15:0] cmd_data // command value
);
	import conv_pkg::*;
	logic ext_clk = 1'b0;
	initial begin
		cmd_valid = 1'b0;
		cmd_code = CMD_NONE;
		cmd_data = 16'h0000;
		vset_strap_code = 4'h4;
		rt_strap_code = 4'h1;
	end
	// free-running external source; on the pin whenever the device is not the master
	always #5000 ext_clk = ~ext_clk;
	assign sync_i = sync_oe ? sync_o : ext_clk;
	task automatic send(input cmd_e code, input logic [15:0] data);
		cmd_code = code;
		cmd_data = data;
		cmd_valid = 1'b1;
		@(posedge clock);
		#1;
		cmd_valid = 1'b0;
		@(posedge clock);
		#1;
	endtask : send
	// open voltage strap hands the output voltage to commands
	task automatic strap(input logic [3:0] vc, rc);
		vset_strap_code = vc;
		rt_strap_code = rc;
	endtask : strap
endmodule : board_host
`default_nettype wire

// [verification/conv_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_properties (
	input wire logic clock, // clock
	input wire logic sys_rst, // reset
	input wire logic supply_lockout_ok, // lockout clear
	input wire logic cmd_valid, // strobe
	input var conv_pkg::cmd_e cmd_code, // command
	input wire logic [15:0] cmd_data, // value
	input wire logic high_side_switch, // high side
	input wire logic low_side_switch, // low side
	input wire logic input_undervoltage_protect, // input uv
	input wire logic powerup_time_protect, // time fault
	input wire logic overtemp_fault, // ot fault
	input wire logic [2:0] fault_sticky, // sticky flags
	input wire logic [15:0] freq_khz, // frequency
	input var conv_pkg::mode_e switch_mode, // mode
	input wire logic sync_oe, // pin enable
	input wire logic sync_o, // pin out
	input wire logic phase_pulse, // period start
	input wire logic [2:0] state_code // state
);
	import conv_pkg::*;
	logic [1:0] mode_req;
	assign mode_req = cmd_data[1:0];
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_uv_off;
		input_undervoltage_protect |-> !high_side_switch && !low_side_switch;
	endproperty
	a_uv_off: assert property (p_uv_off)
		else $error("switch on during input uv");
	property p_time_off;
		powerup_time_protect |-> !high_side_switch && !low_side_switch;
	endproperty
	a_time_off: assert property (p_time_off)
		else $error("switch on during time fault");
	property p_ot_off;
		overtemp_fault |-> !high_side_switch && !low_side_switch;
	endproperty
	a_ot_off: assert property (p_ot_off)
		else $error("switch on during over-temperature");
	property p_sticky_uv;
		input_undervoltage_protect ##1 input_undervoltage_protect |-> fault_sticky[0];
	endproperty
	a_sticky_uv: assert property (p_sticky_uv)
		else $error("input uv sticky missing");
	property p_sticky_ot;
		overtemp_fault ##1 overtemp_fault |-> fault_sticky[2];
	endproperty
	a_sticky_ot: assert property (p_sticky_ot)
		else $error("ot sticky missing");
	property p_start;
		$rose(supply_lockout_ok) && state_code == ST_OFF
			|-> ##3 state_code == ST_SAMPLE ##1 state_code == ST_WAIT;
	endproperty
	a_start: assert property (p_start)
		else $error("start sequence late");
	property p_sync_oe;
		sync_oe == (switch_mode == MODE_MASTER);
	endproperty
	a_sync_oe: assert property (p_sync_oe)
		else $error("sync drive wrong for mode");
	property p_pulse;
		$rose(sync_o) && $past(switch_mode) == MODE_MASTER |-> phase_pulse;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("no period pulse on sync rise");
	property p_freq;
		cmd_valid && cmd_code == CMD_FREQ
			|-> ##2 freq_khz == $past(cmd_data, 2) / 16'h32 * 16'h32;
	endproperty
	a_freq: assert property (p_freq)
		else $error("frequency command not applied");
	property p_mode;
		cmd_valid && cmd_code == CMD_INTERLEAVE
			|-> ##2 switch_mode == $past(mode_req, 2);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode command not applied");
endmodule : conv_properties
bind converter_fault_and_strap_config conv_properties chk (.clock,
	.sys_rst, .supply_lockout_ok, .cmd_valid, .cmd_code, .cmd_data,
	.high_side_switch, .low_side_switch, .input_undervoltage_protect,
	.powerup_time_protect, .overtemp_fault, .fault_sticky, .freq_khz,
	.switch_mode, .sync_oe, .sync_o, .phase_pulse, .state_code);
`default_nettype wire

// [verification/converter_fault_and_strap_config_test.sv]
`timescale 1ns/1ps
`default_nettype none
module converter_fault_and_strap_config_test;
	import conv_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic supply_lockout_ok = 1'b0;
	logic [15:0] vin_mv = 16'h2EE0;
	logic [15:0] vout_mv = 16'h0000;
	logic [7:0] temp_c = 8'h19;
	logic [3:0] vset_strap_code, rt_strap_code;
	logic cmd_valid, sync_i, sync_o, sync_oe;
	cmd_e cmd_code;
	mode_e switch_mode;
	logic [15:0] cmd_data, target_vout_mv, freq_khz;
	logic high_side_switch, low_side_switch, input_undervoltage_protect;
	logic powerup_time_protect, overtemp_fault;
	logic [2:0] fault_sticky, state_code;
	logic [7:0][15:0] vout_limits;
	logic [1:0] loop_scale;
	int bad_count = 0;
	int compares = 0;
	int n;
	logic [15:0] seed = 16'h0007;
	logic [15:0] vtab [1:15] = '{16'h258, 16'h384, 16'h3B6, 16'h3E8, 16'h41A,
		16'h4B0, 16'h4E2, 16'h5DC, 16'h708, 16'h834, 16'h9C4, 16'hCE4,
		16'h1388, 16'h2EE0, 16'h3E8};
	logic [15:0] ftab [1:15] = '{16'h12C, 16'h190, 16'h1F4, 16'h226, 16'h258,
		16'h28A, 16'h2BC, 16'h2EE, 16'h320, 16'h352, 16'h384, 16'h3B6,
		16'h3E8, 16'h4E2, 16'h5DC};
	always #50 clock = ~clock;
	// short ms tick keeps the 20 ms waits near 200 cycles
	converter_fault_and_strap_config #(.TICK_CYCLES(10)) dut (.clock,
		.sys_rst, .supply_lockout_ok, .vin_mv, .vout_mv, .temp_c,
		.vset_strap_code, .rt_strap_code, .cmd_valid, .cmd_code, .cmd_data,
		.sync_i, .sync_o, .sync_oe, .phase_pulse(), .high_side_switch,
		.low_side_switch, .input_undervoltage_protect, .powerup_time_protect,
		.overtemp_fault, .fault_sticky, .target_vout_mv, .vout_limits,
		.loop_scale, .freq_khz, .switch_mode, .state_code);
	board_host host (.clock, .sync_o, .sync_oe, .sync_i, .vset_strap_code,
		.rt_strap_code, .cmd_valid, .cmd_code, .cmd_data);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [15:0] pct_of(input logic [15:0] t, input int i);
		logic [6:0] p [8] = '{7'h5A, 7'h55, 7'h73, 7'h6E, 7'h5A, 7'h50, 7'h5F,
			7'h69};
		return 16'((32'(t) * p[i]) / 32'h64);
	endfunction : pct_of
	function automatic logic [15:0] scale_of(input logic [15:0] mv);
		return (mv <= 16'h5DC) ? 16'h0 : (mv <= 16'hCE4) ? 16'h1 :
			(mv <= 16'h1388) ? 16'h2 : 16'h3;
	endfunction : scale_of
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick
	// percent limits truncate exactly as pct_of does, yet a one-unit slack above the expected value is allowed
	task automatic check(input string what, input logic [15:0] exp, got,
		input int tol);
		compares++;
		if ((got >= exp && got <= exp + tol) !== 1'b1) begin
			bad_count++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check
	task automatic power_up(input logic [3:0] vc, rc);
		supply_lockout_ok = 1'b0;
		host.strap(vc, rc);
		tick(3);
		supply_lockout_ok = 1'b1;
		tick(8);
	endtask : power_up
	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	task automatic temp_step(input logic [7:0] t, input logic ot, hs);
		temp_c = t;
		tick(6);
		check("ot flag", 16'(ot), overtemp_fault, 0);
		check("hs", 16'(hs), high_side_switch, 0);
	endtask : temp_step
	initial begin
		#3000000;
		bad_count++;
		finish_test();
	end
	initial begin
		tick(10);
		sys_rst = 1'b0;
		tick(1);
		check("mode", 16'(MODE_MASTER), switch_mode, 0);
		for (int c = 1; c <= 15; c++) begin
			power_up(4'(c), 4'(c));
			check("target", vtab[c], target_vout_mv, 0);
			check("freq", ftab[c], freq_khz, 0);
			check("scale", scale_of(vtab[c]), loop_scale, 0);
			check("start", 16'h3, state_code, 0);
			check("hs", 16'h1, high_side_switch, 0);
			for (int i = 0; i < 8 && c < 15; i++)
				check("limit", pct_of(vtab[c], i), vout_limits[i], 1);
		end
		repeat (4) begin
			seed = lfsr(seed);
			host.send(CMD_FREQ, 16'h12C + seed[9:0]);
			tick(1);
			check("freq cmd", (16'h12C + seed[9:0]) / 16'h32 * 16'h32, freq_khz,
				0);
			host.send(CMD_VOUT, {5'h00, seed[2:0], 8'h00} + 16'h0100);
			check("vout cmd", 16'h1F4 * (16'(seed[2:0]) + 16'h1), target_vout_mv,
				0);
		end
		host.send(CMD_UV_LIMIT, 16'h2BC);
		tick(1);
		check("uv limit", 16'h2BC, vout_limits[5], 0);
		for (int m = 0; m < 4; m++) begin
			host.send(CMD_INTERLEAVE, 16'(m));
			check("mode", 16'(m), switch_mode, 0);
			check("sync drive", 16'(m == 1), sync_oe, 0);
		end
		host.send(CMD_INTERLEAVE, 16'h1);
		host.send(CMD_VOUT, 16'h0200);
		vout_mv = 16'h384;
		tick(3);
		check("run", 16'h4, state_code, 0);
		vin_mv = 16'h2327;
		tick(3);
		check("in uv", 16'h1, input_undervoltage_protect, 0);
		check("hs", 16'h0, high_side_switch, 0);
		vin_mv = 16'h251C;
		tick(3);
		check("in uv hold", 16'h1, input_undervoltage_protect, 0);
		vin_mv = 16'h2711;
		tick(8);
		check("in uv", 16'h0, input_undervoltage_protect, 0);
		check("hs", 16'h1, high_side_switch, 0);
		check("sticky", 16'h1, fault_sticky, 0);
		host.send(CMD_CLEAR, 16'h0000);
		check("sticky", 16'h0, fault_sticky, 0);
		host.send(CMD_VIN_ON, 16'h2EE0);
		host.send(CMD_VIN_OFF, 16'h2AF8);
		tick(2);
		check("in uv", 16'h1, input_undervoltage_protect, 0);
		host.send(CMD_VIN_OFF, 16'h2328);
		check("in uv hold", 16'h1, input_undervoltage_protect, 0);
		vin_mv = 16'h2EE1;
		temp_step(8'h7D, 1'b0, 1'b1);
		temp_step(8'h7E, 1'b1, 1'b0);
		temp_step(8'h64, 1'b0, 1'b1);
		host.send(CMD_OT_LIMIT, 16'h005A);
		temp_step(8'h64, 1'b1, 1'b0);
		host.send(CMD_OT_LIMIT, 16'h007D);
		vout_mv = 16'h4B0;
		power_up(4'hF, 4'h1);
		check("prebias hs", 16'h0, high_side_switch, 0);
		vout_mv = 16'h0000;
		tick(3);
		check("hs", 16'h1, high_side_switch, 0);
		tick(170);
		check("early fault", 16'h0, powerup_time_protect, 0);
		for (n = 0; powerup_time_protect !== 1'b1 && n < 50; n++) tick(1);
		check("time fault", 16'h1, powerup_time_protect, 0);
		for (n = 0; high_side_switch !== 1'b1 && n < 300; n++) tick(1);
		check("retry wait", 16'hBE, 16'(n), 25);
		host.send(CMD_TON_MAX, 16'h0003);
		host.send(CMD_RETRY, 16'h0004);
		power_up(4'hF, 4'h1);
		for (n = 0; powerup_time_protect !== 1'b1 && n < 45; n++) tick(1);
		check("short limit", 16'h1, powerup_time_protect, 0);
		for (n = 0; high_side_switch !== 1'b1 && n < 60; n++) tick(1);
		check("short retry", 16'h21, 16'(n), 9);
		check("sticky all", 16'h7, fault_sticky, 0);
		finish_test();
	end
endmodule : converter_fault_and_strap_config_test
`default_nettype wire
